// file: ulf_host.sv
// Bus master model standing in for the host processor.
// Assumes one slave whose ready output is fed back as HREADY.
`timescale 1ns/1ns
module ulf_host
    import ulf_pkg::*;
(
    input wire logic CLK,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    output logic HSEL,
    output logic [31:0] HADDR,
    output logic [1:0] HTRANS,
    output logic HWRITE,
    output logic [2:0] HSIZE,
    output logic [31:0] HWDATA
);
    // Bus idle at time zero, word transfers only
    initial begin
        HSEL = 1'b0;
        HTRANS = 2'h0;
        HADDR = 32'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
    end
    // One single transfer; released address and write data show the inverse of their value
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        @(posedge CLK);
        while (!HREADY) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HADDR <= ~{24'h0, a};
        HWDATA <= wd;
        @(posedge CLK);
        while (!HREADY) @(posedge CLK);
        rd = HRDATA;
        HWDATA <= ~wd;
    endtask
endmodule // ulf_host

// file: ulf_parity.sv
// Parity generator and checker for one character.
// Assumes data sits in the low bits; bits above the word length are ignored.
`timescale 1ns/1ns
module ulf_parity
    import ulf_pkg::*;
(
    input wire logic [7:0] data,
    input wire logic [1:0] wlen,
    input wire logic [2:0] field,
    output logic par_en,
    output ulf_par_t par_kind,
    output logic par_bit
);
    logic [7:0] mask;
    logic ones;

    // Keep only the bits of the programmed word length
    always_comb begin
        mask = 8'h1f;
        case (wlen)
            2'b00: mask = 8'h1f;
            2'b01: mask = 8'h3f;
            2'b10: mask = 8'h7f;
            default: mask = 8'hff;
        endcase
        ones = ^(data & mask);
    end

    // Parity kind from the field, then the bit itself
    always_comb begin
        par_en = field[0];
        case (field[2:1])
            2'b00: par_kind = ULF_PAR_ODD;
            2'b01: par_kind = ULF_PAR_EVEN;
            2'b10: par_kind = ULF_PAR_ONE;
            default: par_kind = ULF_PAR_ZERO;
        endcase
        case (par_kind)
            ULF_PAR_ODD: par_bit = ~ones;
            ULF_PAR_EVEN: par_bit = ones;
            ULF_PAR_ONE: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    end
endmodule // ulf_parity

// file: ulf_pkg.sv
// Package for the serial line format and interrupt status block.
// Assumes one 125 MHz clock and an AHB-Lite register bus of one slave.
package ulf_pkg;

    // Register byte offsets
    localparam logic [7:0] ULF_OFF_DATA = 8'h00;
    localparam logic [7:0] ULF_OFF_IEN = 8'h04;
    localparam logic [7:0] ULF_OFF_ISTAT = 8'h08;
    localparam logic [7:0] ULF_OFF_LFMT = 8'h0c;
    localparam logic [7:0] ULF_OFF_FMODE = 8'h10;

    // Line format fields
    localparam int ULF_LF_DLAB = 7;
    localparam int ULF_LF_BRK = 6;
    localparam int ULF_LF_PAR_HI = 5;
    localparam int ULF_LF_PAR_LO = 3;
    localparam int ULF_LF_STOP = 2;
    localparam int ULF_LF_WLEN_HI = 1;
    localparam int ULF_LF_WLEN_LO = 0;
    localparam logic [7:0] ULF_LF_RST = 8'h00;

    // Interrupt enable fields
    localparam int ULF_IE_RX = 0;
    localparam int ULF_IE_THRE = 1;
    localparam int ULF_IE_LS = 2;
    localparam int ULF_IE_MS = 3;
    localparam logic [7:0] ULF_IE_RST = 8'h00;

    // Interrupt source codes, status bits 3:0
    localparam logic [3:0] ULF_IC_LS = 4'h6;
    localparam logic [3:0] ULF_IC_RXD = 4'h4;
    localparam logic [3:0] ULF_IC_RXTO = 4'hc;
    localparam logic [3:0] ULF_IC_THRE = 4'h2;
    localparam logic [3:0] ULF_IC_MS = 4'h0;
    localparam logic [3:0] ULF_IC_NONE = 4'h1;
    localparam logic [1:0] ULF_FIFO_ON_BITS = 2'h3;
    localparam logic [1:0] ULF_FIFO_OFF_BITS = 2'h0;
    localparam logic [1:0] ULF_IS_UNUSED = 2'h0;

    // Other reset values
    localparam logic [7:0] ULF_DIV_RST = 8'h00;
    localparam logic [7:0] ULF_EFR_RST = 8'h00;
    localparam logic ULF_TXD_IDLE = 1'b1;

    // Stop length in half bit times and word length base
    localparam logic [2:0] ULF_STOP_ONE = 3'h2;
    localparam logic [2:0] ULF_STOP_ONEHALF = 3'h3;
    localparam logic [2:0] ULF_STOP_TWO = 3'h4;
    localparam logic [3:0] ULF_WLEN_BASE = 4'h5;

    // Parity kinds
    typedef enum logic [1:0] {
        ULF_PAR_ODD = 2'b00,
        ULF_PAR_EVEN = 2'b01,
        ULF_PAR_ONE = 2'b10,
        ULF_PAR_ZERO = 2'b11
    } ulf_par_t;

    // Character format handed to the serializer and deserializer
    typedef struct packed {
        logic [3:0] word_bits;
        logic [2:0] stop_halves;
        logic parity_en;
        ulf_par_t parity_kind;
    } ulf_format_t;

    // Bus transfer progress
    typedef enum logic [1:0] {
        ULF_BUS_IDLE = 2'b00,
        ULF_BUS_WRITE = 2'b01,
        ULF_BUS_RWAIT = 2'b10,
        ULF_BUS_RDONE = 2'b11
    } ulf_bus_t;

endpackage

// file: ulf_top.sv
// Line format control and interrupt status of one serial channel.
// Assumes an AHB-Lite master on CLK; interrupt sources, serializer and
// receive data come from logic on the same clock, so none is synchronised.
`timescale 1ns/1ns
module ulf_top
    import ulf_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic LINE_ERROR_STATUS,
    input wire logic RECEIVE_DATA_AVAILABLE,
    input wire logic RECEIVE_TIMEOUT,
    input wire logic TRANSMIT_HOLDING_EMPTY,
    input wire logic MODEM_STATUS,
    input wire logic SER_TXD,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_PARITY,
    input wire logic RX_STROBE,
    output logic TXD,
    output logic [7:0] TX_DATA,
    output logic TX_PARITY,
    output logic TX_LOAD,
    output logic RX_READ,
    output logic PARITY_ERR,
    output ulf_format_t FORMAT,
    output logic [15:0] DIVISOR,
    output logic [7:0] ENHANCED,
    output logic FIFO_MODE
);

    // All state of the block
    typedef struct packed {
        ulf_bus_t bus;
        logic [7:0] addr;
        logic [7:0] lfmt;
        logic [7:0] ien;
        logic fifo_on;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] efr;
        logic thre_flag;
        logic thre_seen;
        logic [31:0] rdata;
        logic [7:0] tx_data;
        logic tx_par;
        logic tx_load;
        logic rx_read;
        logic txd;
        logic par_err;
    } ulf_state_t;

    ulf_state_t s_q;
    ulf_state_t s_d;

    logic accept;
    logic [7:0] wbyte;
    logic dlab;
    logic pend_ls;
    logic pend_rxd;
    logic pend_rxto;
    logic pend_thre;
    logic pend_ms;
    logic [3:0] int_code;
    logic [7:0] istat;
    logic tx_par_en;
    logic tx_par_bit;
    logic rx_par_en;
    logic rx_par_bit;
    ulf_par_t tx_kind;
    logic thre_rise;
    logic thre_clr;
    logic tx_write;

    // Byte offset match used by both the read and the write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // Priority encoder of the pending sources into a status code
    function automatic logic [3:0] prio(input logic ls, input logic rxd,
                                        input logic rxto, input logic thre,
                                        input logic ms);
        if (ls) begin
            prio = ULF_IC_LS;
        end else if (rxd) begin
            prio = ULF_IC_RXD;
        end else if (rxto) begin
            prio = ULF_IC_RXTO;
        end else if (thre) begin
            prio = ULF_IC_THRE;
        end else if (ms) begin
            prio = ULF_IC_MS;
        end else begin
            prio = ULF_IC_NONE;
        end
    endfunction

    // Parity of the character being loaded for transmission
    ulf_parity u_tx_par (
        .data(wbyte),
        .wlen(s_q.lfmt[ULF_LF_WLEN_HI:ULF_LF_WLEN_LO]),
        .field(s_q.lfmt[ULF_LF_PAR_HI:ULF_LF_PAR_LO]),
        .par_en(tx_par_en),
        .par_kind(tx_kind),
        .par_bit(tx_par_bit)
    );

    // Parity expected on the character just received
    ulf_parity u_rx_par (
        .data(RX_DATA),
        .wlen(s_q.lfmt[ULF_LF_WLEN_HI:ULF_LF_WLEN_LO]),
        .field(s_q.lfmt[ULF_LF_PAR_HI:ULF_LF_PAR_LO]),
        .par_en(rx_par_en),
        .par_kind(),
        .par_bit(rx_par_bit)
    );

    // Enabled sources; timeout only exists with the FIFOs on
    always_comb begin
        dlab = s_q.lfmt[ULF_LF_DLAB];
        pend_ls = LINE_ERROR_STATUS & s_q.ien[ULF_IE_LS];
        pend_rxd = RECEIVE_DATA_AVAILABLE & s_q.ien[ULF_IE_RX];
        pend_rxto = RECEIVE_TIMEOUT & s_q.ien[ULF_IE_RX] & s_q.fifo_on;
        pend_thre = s_q.thre_flag & s_q.ien[ULF_IE_THRE];
        pend_ms = MODEM_STATUS & s_q.ien[ULF_IE_MS];
        int_code = prio(pend_ls, pend_rxd, pend_rxto, pend_thre, pend_ms);
        istat = {(s_q.fifo_on ? ULF_FIFO_ON_BITS : ULF_FIFO_OFF_BITS),
                 ULF_IS_UNUSED, int_code};
    end

    // Bus acceptance and the transmit empty edge
    always_comb begin
        accept = HSEL & HTRANS[1] & HREADY;
        wbyte = HWDATA[7:0];
        thre_rise = TRANSMIT_HOLDING_EMPTY & ~s_q.thre_seen;
        tx_write = (s_q.bus == ULF_BUS_WRITE) & ~dlab &
                   hit(s_q.addr, ULF_OFF_DATA);
        thre_clr = tx_write |
                   ((s_q.bus == ULF_BUS_RWAIT) & ~dlab &
                    hit(s_q.addr, ULF_OFF_ISTAT) &
                    (int_code == ULF_IC_THRE));
    end

    // Next state: bus phases, register writes, reads and line outputs
    always_comb begin
        s_d = s_q;
        s_d.tx_load = 1'b0;
        s_d.rx_read = 1'b0;
        s_d.par_err = 1'b0;
        s_d.thre_seen = TRANSMIT_HOLDING_EMPTY;
        // Break holds the line low for as long as the bit is set
        s_d.txd = SER_TXD & ~s_q.lfmt[ULF_LF_BRK];
        // A set in the same cycle as a clear wins
        if (thre_rise) begin
            s_d.thre_flag = 1'b1;
        end else if (thre_clr) begin
            s_d.thre_flag = 1'b0;
        end
        // Parity check of a received character
        if (RX_STROBE) begin
            s_d.par_err = rx_par_en & (RX_PARITY != rx_par_bit);
        end
        case (s_q.bus)
            ULF_BUS_WRITE: begin
                // Data phase of a write: store the low byte
                if (hit(s_q.addr, ULF_OFF_DATA)) begin
                    if (dlab) begin
                        s_d.div_lo = wbyte;
                    end else begin
                        s_d.tx_data = wbyte;
                        s_d.tx_par = tx_par_en & tx_par_bit;
                        s_d.tx_load = 1'b1;
                    end
                end else if (hit(s_q.addr, ULF_OFF_IEN)) begin
                    if (dlab) begin
                        s_d.div_hi = wbyte;
                    end else begin
                        s_d.ien = wbyte;
                    end
                end else if (hit(s_q.addr, ULF_OFF_ISTAT)) begin
                    if (dlab) begin
                        s_d.efr = wbyte;
                    end
                end else if (hit(s_q.addr, ULF_OFF_LFMT)) begin
                    s_d.lfmt = wbyte;
                end else if (hit(s_q.addr, ULF_OFF_FMODE)) begin
                    s_d.fifo_on = wbyte[0];
                end
            end
            ULF_BUS_RWAIT: begin
                // Wait state of a read: latch the word and its side effect
                s_d.rdata = 32'h0000_0000;
                if (hit(s_q.addr, ULF_OFF_DATA)) begin
                    if (dlab) begin
                        s_d.rdata[7:0] = s_q.div_lo;
                    end else begin
                        s_d.rdata[7:0] = RX_DATA;
                        s_d.rx_read = 1'b1;
                    end
                end else if (hit(s_q.addr, ULF_OFF_IEN)) begin
                    s_d.rdata[7:0] = dlab ? s_q.div_hi : s_q.ien;
                end else if (hit(s_q.addr, ULF_OFF_ISTAT)) begin
                    s_d.rdata[7:0] = dlab ? s_q.efr : istat;
                end else if (hit(s_q.addr, ULF_OFF_LFMT)) begin
                    s_d.rdata[7:0] = s_q.lfmt;
                end else if (hit(s_q.addr, ULF_OFF_FMODE)) begin
                    s_d.rdata[0] = s_q.fifo_on;
                end
            end
            default: begin
            end
        endcase
        // Phase sequencing; no new address phase while the bus is stalled
        if (s_q.bus == ULF_BUS_RWAIT) begin
            s_d.bus = ULF_BUS_RDONE;
        end else if (accept) begin
            s_d.addr = HADDR[7:0];
            s_d.bus = HWRITE ? ULF_BUS_WRITE : ULF_BUS_RWAIT;
        end else begin
            s_d.bus = ULF_BUS_IDLE;
        end
    end

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q.bus <= ULF_BUS_IDLE;
            s_q.addr <= 8'h00;
            s_q.lfmt <= ULF_LF_RST;
            s_q.ien <= ULF_IE_RST;
            s_q.fifo_on <= 1'b0;
            s_q.div_lo <= ULF_DIV_RST;
            s_q.div_hi <= ULF_DIV_RST;
            s_q.efr <= ULF_EFR_RST;
            s_q.thre_flag <= 1'b0;
            s_q.thre_seen <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.tx_data <= 8'h00;
            s_q.tx_par <= 1'b0;
            s_q.tx_load <= 1'b0;
            s_q.rx_read <= 1'b0;
            s_q.txd <= ULF_TXD_IDLE;
            s_q.par_err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Format decode handed to the serializer and deserializer
    always_comb begin
        FORMAT.word_bits = ULF_WLEN_BASE +
                           {2'b00, s_q.lfmt[ULF_LF_WLEN_HI:ULF_LF_WLEN_LO]};
        if (!s_q.lfmt[ULF_LF_STOP]) begin
            FORMAT.stop_halves = ULF_STOP_ONE;
        end else if (s_q.lfmt[ULF_LF_WLEN_HI:ULF_LF_WLEN_LO] == 2'b00) begin
            FORMAT.stop_halves = ULF_STOP_ONEHALF;
        end else begin
            FORMAT.stop_halves = ULF_STOP_TWO;
        end
        FORMAT.parity_en = tx_par_en;
        FORMAT.parity_kind = tx_kind;
    end

    // Bus answers: reads take one wait state, writes none, always OKAY
    assign HREADYOUT = (s_q.bus != ULF_BUS_RWAIT);
    assign HRESP = 1'b0;
    assign HRDATA = s_q.rdata;

    // Line side outputs
    assign TXD = s_q.txd;
    assign TX_DATA = s_q.tx_data;
    assign TX_PARITY = s_q.tx_par;
    assign TX_LOAD = s_q.tx_load;
    assign RX_READ = s_q.rx_read;
    assign PARITY_ERR = s_q.par_err;
    assign DIVISOR = {s_q.div_hi, s_q.div_lo};
    assign ENHANCED = s_q.efr;
    assign FIFO_MODE = s_q.fifo_on;

endmodule // ulf_top

// file: ulf_top_chk.sv
// Checker of bus waits, line format decode, break and status reads.
// Assumes it is bound to the block top and sees its ports only.
`timescale 1ns/1ns
module ulf_top_chk
    import ulf_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic LINE_ERROR_STATUS,
    input wire logic SER_TXD,
    input wire logic RX_STROBE,
    input wire logic TXD,
    input wire logic PARITY_ERR,
    input wire ulf_format_t FORMAT,
    input wire logic FIFO_MODE
);
    logic take, st_rd, wl_q, wi_q;
    logic [7:0] lf_q, ie_q;
    assign take = HSEL & HTRANS[1] & HREADY;
    assign st_rd = take & !HWRITE & (HADDR[7:2] == 6'h2) & !lf_q[7];
    // Shadow copies of the line format and enable registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {wl_q, wi_q, lf_q, ie_q} <= 18'h0;
        end else begin
            wl_q <= take & HWRITE & (HADDR[7:2] == 6'h3);
            wi_q <= take & HWRITE & (HADDR[7:2] == 6'h1) & !lf_q[7];
            if (wl_q)
                lf_q <= HWDATA[7:0];
            if (wi_q)
                ie_q <= HWDATA[7:0];
        end
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    chk_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1
        HREADYOUT) else $error("read wait is not one cycle");
    chk_break_low: assert property (!$past(RST) |->
        TXD == $past(SER_TXD & ~lf_q[6])) else $error("line level wrong");
    chk_word_len: assert property (
        FORMAT.word_bits == ULF_WLEN_BASE + lf_q[1:0])
        else $error("word length wrong");
    chk_stop_len: assert property (FORMAT.stop_halves == (!lf_q[2] ?
        ULF_STOP_ONE : lf_q[1:0] == 2'h0 ? ULF_STOP_ONEHALF : ULF_STOP_TWO))
        else $error("stop length wrong");
    chk_parity_on: assert property (FORMAT.parity_en == lf_q[3])
        else $error("parity enable wrong");
    chk_parity_kind: assert property (lf_q[3] |->
        FORMAT.parity_kind == lf_q[5:4]) else $error("parity kind wrong");
    chk_perr_cause: assert property (PARITY_ERR |->
        $past(RX_STROBE & lf_q[3])) else $error("parity error uncaused");
    chk_status_form: assert property (st_rd |=> ##1
        (HRDATA[31:8] == 24'h0 && HRDATA[7:6] == {2{FIFO_MODE}} &&
        HRDATA[5:4] == 2'h0 && (!HRDATA[0] || HRDATA[3:1] == 3'h0)))
        else $error("status format wrong");
    chk_line_err_top: assert property (st_rd ##1
        (LINE_ERROR_STATUS && ie_q[2]) |=> HRDATA[3:0] == ULF_IC_LS)
        else $error("line error not reported first");
endmodule // ulf_top_chk

bind ulf_top ulf_top_chk u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .LINE_ERROR_STATUS(LINE_ERROR_STATUS), .SER_TXD(SER_TXD),
    .RX_STROBE(RX_STROBE), .TXD(TXD), .PARITY_ERR(PARITY_ERR),
    .FORMAT(FORMAT), .FIFO_MODE(FIFO_MODE));

// file: ulf_top_test.sv
// Self-checking bench of the line format and interrupt status block.
// Assumes the host model as bus master and a 125 MHz clock.
`timescale 1ns/1ns
module ulf_top_test
    import ulf_pkg::*;
    ;
    logic clk, rst, hsel, hwrite, hrdy, ser_txd, rx_par, rx_stb, txd;
    logic tx_par, tx_load, par_err, fifo, hresp, rx_read;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] src;
    logic [7:0] rx_data, enh, d, tx_data;
    logic [15:0] div;
    ulf_format_t fmt;
    int fails, tests_run, seed;
    logic [4:0] ws [6] = '{5'h1f, 5'h0f, 5'h07, 5'h03, 5'h03, 5'h00};
    logic [7:0] we [6] = '{8'hc6, 8'hc4, 8'hcc, 8'hc2, 8'hc0, 8'hc1};

    ulf_top DUT (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .LINE_ERROR_STATUS(src[4]), .RECEIVE_DATA_AVAILABLE(src[3]),
        .RECEIVE_TIMEOUT(src[2]), .TRANSMIT_HOLDING_EMPTY(src[1]),
        .MODEM_STATUS(src[0]), .SER_TXD(ser_txd), .RX_DATA(rx_data),
        .RX_PARITY(rx_par), .RX_STROBE(rx_stb), .TXD(txd), .TX_DATA(tx_data),
        .TX_PARITY(tx_par), .TX_LOAD(tx_load), .RX_READ(rx_read),
        .PARITY_ERR(par_err), .FORMAT(fmt), .DIVISOR(div),
        .ENHANCED(enh), .FIFO_MODE(fifo));
    ulf_host host (.CLK(clk), .HREADY(hrdy), .HRDATA(hrdata),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata));

    // Clock and a random serial stream into the line driver
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) ser_txd <= 1'($random(seed));

    // Count a comparison and report a mismatch
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.xfer(1'b1, a, {24'h0, v}, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
    endtask
    // Parity bit for a character under a format code
    function automatic logic exp_par(input logic [7:0] v, input int lf);
        logic [7:0] m;
        m = v & (8'hff >> (3 - lf % 4));
        case (lf[5:3])
            3'b001: return ~^m;
            3'b011: return ^m;
            3'b101: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the fewer than a thousand cycles the run needs
    initial begin
        #100000;
        fails++;
        test_done();
    end

    // Main sequence
    initial begin
        {seed, fails, tests_run} = {32'd14, 64'd0};
        {rst, src, rx_data, rx_par, rx_stb} = {1'b1, 16'h0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(ULF_OFF_LFMT, 32'h0);
        rdchk(ULF_OFF_ISTAT, 32'h1);
        cmp(fmt, {4'h5, ULF_STOP_ONE, 1'b0, ULF_PAR_ODD});
        $display("test reset done");
        // Every format code, a random character sent and received
        for (int i = 0; i < 64; i++) begin
            d = 8'($random(seed));
            wr(ULF_OFF_LFMT, i[7:0]);
            rdchk(ULF_OFF_LFMT, i);
            cmp(fmt.word_bits, 5 + i % 4);
            cmp(fmt.stop_halves, !i[2] ? 2 : (i % 4 == 0 ? 3 : 4));
            cmp(fmt.parity_en, i[3]);
            if (i[3])
                cmp(fmt.parity_kind, i[5:4]);
            wr(ULF_OFF_DATA, d);
            #1 cmp({tx_load, tx_par, tx_data, hresp},
                   {1'b1, exp_par(d, i), d, 1'b0});
            rx_data <= d;
            rx_par <= ~exp_par(d, i);
            rx_stb <= 1'b1;
            @(posedge clk);
            rx_stb <= 1'b0;
            #1 cmp(par_err, i[3]);
            rdchk(ULF_OFF_DATA, {24'h0, d});
            cmp({rx_read, hresp}, 2'b10);
        end
        $display("test formats done");
        // Break holds the line low whatever the serial stream does
        wr(ULF_OFF_LFMT, 8'h43);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1 cmp(txd, 1'b0);
        end
        wr(ULF_OFF_LFMT, 8'h03);
        $display("test break done");
        // Divisor access redirects the low offsets
        wr(ULF_OFF_LFMT, 8'h80);
        wr(ULF_OFF_DATA, 8'h5a);
        wr(ULF_OFF_IEN, 8'hc3);
        wr(ULF_OFF_ISTAT, 8'h7e);
        #1 cmp({div, enh}, 24'hc35a7e);
        rdchk(ULF_OFF_ISTAT, 32'h7e);
        rdchk(ULF_OFF_DATA, 32'h5a);
        cmp(rx_read, 1'b0);
        wr(ULF_OFF_LFMT, 8'h00);
        wr(ULF_OFF_ISTAT, 8'hff);
        wr(8'h20, 8'hff);
        rdchk(8'h20, 32'h0);
        rdchk(ULF_OFF_ISTAT, 32'h1);
        $display("test divisor done");
        // Priority walk with FIFOs on, then masked, then FIFOs off
        wr(ULF_OFF_FMODE, 8'h01);
        wr(ULF_OFF_IEN, 8'h0f);
        src <= 5'h02;
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            src <= ws[k];
            rdchk(ULF_OFF_ISTAT, we[k]);
        end
        wr(ULF_OFF_IEN, 8'h00);
        src <= 5'h1f;
        rdchk(ULF_OFF_ISTAT, 32'hc1);
        wr(ULF_OFF_FMODE, 8'h00);
        wr(ULF_OFF_IEN, 8'h0f);
        rdchk(ULF_OFF_ISTAT, 32'h06);
        src <= 5'h04;
        rdchk(ULF_OFF_ISTAT, 32'h02);
        rdchk(ULF_OFF_ISTAT, 32'h01);
        $display("test status done");
        // Reset in mid-run puts every field back to its default
        wr(ULF_OFF_FMODE, 8'h01);
        wr(ULF_OFF_LFMT, 8'hff);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        cmp({fifo, div, enh, txd, tx_load, hresp}, {1'b0, 24'h0, 3'b100});
        cmp(fmt, {4'h5, ULF_STOP_ONE, 1'b0, ULF_PAR_ODD});
        rst <= 1'b0;
        @(posedge clk);
        rdchk(ULF_OFF_LFMT, 32'h0);
        rdchk(ULF_OFF_ISTAT, 32'h1);
        $display("test reset again done");
        test_done();
    end
endmodule // ulf_top_test
